// ### pkg/tiod_pkg.sv
// Purpose: shared constants for the timer i/o control decode block
// Assumes: 100 MHz peripheral clock, AXI4-Lite register access, 4 decoded channels
// Notes:   field of each control register sits in bits 7:4
package tiod_pkg;
  localparam int unsigned NUM_CH   = 4;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned IO_W     = 8;
  localparam int unsigned FLD_LSB  = 4;
  localparam int unsigned FLD_W    = 4;
  localparam int unsigned CTRL_W   = 16;
  localparam int unsigned PSC_W    = 3;
  // register byte offsets
  localparam logic [7:0] OFF_CH0_IO = 8'h00;
  localparam logic [7:0] OFF_CH1_IO = 8'h04;
  localparam logic [7:0] OFF_CH2_IO = 8'h08;
  localparam logic [7:0] OFF_CH3_IO = 8'h0c;
  localparam logic [7:0] OFF_CTRL   = 8'h10;
  localparam logic [7:0] OFF_STAT   = 8'h14;
  localparam logic [7:0] OFF_CAP0   = 8'h18;
  localparam logic [7:0] OFF_STEP   = 8'h04;
  // field bit positions
  localparam int unsigned FB_CAPTURE = 3;
  localparam int unsigned FB_INIT    = 2;
  localparam int unsigned FB_ACT1    = 1;
  localparam int unsigned FB_ACT0    = 0;
  localparam logic [1:0] ACT_CLR = 2'h1;
  localparam logic [1:0] ACT_SET = 2'h2;
  localparam logic [1:0] ACT_TGL = 2'h3;
  localparam logic [1:0] ACT_OFF = 2'h0;
  // control register layout
  localparam int unsigned CTRL_RUN_LSB  = 0;
  localparam int unsigned CTRL_DBUF_BIT = 4;
  localparam int unsigned CTRL_PSC1_LSB = 8;
  localparam int unsigned CTRL_PSC4_LSB = 12;
  localparam logic [2:0]  PSC_UNDIVIDED = 3'h0;
  // status register layout
  localparam int unsigned STAT_LVL_LSB = 0;
  localparam int unsigned STAT_OE_LSB  = 4;
  localparam int unsigned STAT_CAP_LSB = 8;
  localparam int unsigned STAT_PIN_LSB = 12;
  // reset values
  localparam logic [7:0]  IO_RST   = 8'h00;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // channels that own a cross-channel capture source
  localparam logic [3:0]  CROSS_PRESENT = 4'hb;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : tiod_pkg

// ### pkg/chan_if.sv
// Purpose: carries one channel's setup and events between top and channel decoder
// Assumes: single clock domain
// Notes:   field is the four-bit control code
`timescale 1ns/1ps
interface chan_if;
  logic [3:0] field;
  logic       ignore;
  logic       run;
  logic       cross_event;
  logic       cmp_match;
  logic       pin_rise;
  logic       pin_fall;
  logic       level;
  logic       oe;
  logic       capture;
  modport top  (output field, ignore, run, cross_event, cmp_match, pin_rise, pin_fall,
                input level, oe, capture);
  modport chan (input field, ignore, run, cross_event, cmp_match, pin_rise, pin_fall,
                output level, oe, capture);
endinterface : chan_if

// ### src/pin_edge_sync.sv
// Purpose: two-stage pin synchroniser with registered edge pulses
// Assumes: pin is asynchronous to clk_in
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pin_edge_sync (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic rise;
    logic fall;
  } sync_state_t;
  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.s1   = pin_in;
    state_next.s2   = state_reg.s1;
    state_next.prev = state_reg.s2;
    state_next.rise = state_reg.s2 & ~state_reg.prev;
    state_next.fall = ~state_reg.s2 & state_reg.prev;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.prev;
  assign rise_out  = state_reg.rise;
  assign fall_out  = state_reg.fall;
endmodule : pin_edge_sync

// ### src/chan_decode.sv
// Purpose: decodes one four-bit field into pin output or capture strobe
// Assumes: compare match and cross events are one-cycle pulses on clk_in
// Notes:   HAS_CROSS selects whether codes 11xx use the cross-channel source
`timescale 1ns/1ps
module chan_decode #(
  parameter bit HAS_CROSS = 1'b1
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  chan_if.chan      cbus
);
  typedef struct packed {
    logic level;
    logic oe;
    logic capture;
  } chan_state_t;
  chan_state_t state_reg;
  chan_state_t state_next;
  logic [1:0]  act;

  always_comb begin
    act                = cbus.field[tiod_pkg::FB_ACT1:tiod_pkg::FB_ACT0];
    state_next         = state_reg;
    state_next.capture = 1'b0;
    state_next.oe      = 1'b0;
    if (cbus.ignore) begin
      state_next.capture = 1'b0;
    end else if (!cbus.field[tiod_pkg::FB_CAPTURE]) begin
      state_next.oe = (act != tiod_pkg::ACT_OFF);
      if (!cbus.run) begin
        state_next.level = cbus.field[tiod_pkg::FB_INIT];
      end else if (cbus.cmp_match) begin
        case (act)
          tiod_pkg::ACT_CLR: state_next.level = 1'b0;
          tiod_pkg::ACT_SET: state_next.level = 1'b1;
          tiod_pkg::ACT_TGL: state_next.level = ~state_reg.level;
          default:           state_next.level = state_reg.level;
        endcase
      end
    end else if (HAS_CROSS && cbus.field[tiod_pkg::FB_INIT]) begin
      state_next.capture = cbus.cross_event;
    end else if (cbus.field[tiod_pkg::FB_ACT1]) begin
      // bit 6 ignored without cross source
      state_next.capture = cbus.pin_rise | cbus.pin_fall;
    end else if (cbus.field[tiod_pkg::FB_ACT0]) begin
      state_next.capture = cbus.pin_fall;
    end else begin
      state_next.capture = cbus.pin_rise;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cbus.level   = state_reg.level;
  assign cbus.oe      = state_reg.oe;
  assign cbus.capture = state_reg.capture;
endmodule : chan_decode

// ### src/timer_io_control_decode.sv
// Purpose: timer general register i/o control decode for ch0 D and ch1..ch3 B
// Assumes: AXI4-Lite slave, one write and one read outstanding at most
// Notes:   counter, prescaler and compare logic live outside; joined by ports
`timescale 1ns/1ps
// Contract
// - top field bit 0 means compare; x000 codes leave pin output off
// - compare codes 0101 to 0111 start the pin high
// - compare pair 01 clears pin on match, 10 sets it
// - compare pair 11 toggles pin on every match
// - code 1000 captures counter on rising edge of own pin
// - code 1001 captures counter on falling edge of own pin
// - code 101x captures on both edges of own pin
// - channel 0 D code 11xx captures on each channel 1 count
// - channel 3 B code 11xx captures on each channel 4 count
// - channel 1 B code 11xx captures on channel 0 C match or capture
// - channel 2 B ignores bit 6 in capture; no cross source
// - channel 0 cross capture blocked while channel 1 prescale is 000
// - channel 0 D field ignored while its buffer mode is on
// - pin captures use each channel's own dedicated pin
// - channel 3 cross capture blocked while channel 4 prescale is 000
// - initial pin level applies only while the counter is stopped
module timer_io_control_decode (
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  input  wire logic [7:0]             s_axi_awaddr_in,
  input  wire logic                   s_axi_awvalid_in,
  output logic                        s_axi_awready_out,
  input  wire logic [31:0]            s_axi_wdata_in,
  input  wire logic [3:0]             s_axi_wstrb_in,
  input  wire logic                   s_axi_wvalid_in,
  output logic                        s_axi_wready_out,
  output logic [1:0]                  s_axi_bresp_out,
  output logic                        s_axi_bvalid_out,
  input  wire logic                   s_axi_bready_in,
  input  wire logic [7:0]             s_axi_araddr_in,
  input  wire logic                   s_axi_arvalid_in,
  output logic                        s_axi_arready_out,
  output logic [31:0]                 s_axi_rdata_out,
  output logic [1:0]                  s_axi_rresp_out,
  output logic                        s_axi_rvalid_out,
  input  wire logic                   s_axi_rready_in,
  input  wire logic [3:0]             timer_pin_in,
  output logic [3:0]                  timer_pin_out,
  output logic [3:0]                  timer_pin_oe_out,
  input  wire logic [3:0]             cmp_match_in,
  input  wire logic [3:0][15:0]       count_in,
  input  wire logic                   ch1_count_tick_in,
  input  wire logic                   ch4_count_tick_in,
  input  wire logic                   ch0_c_event_in,
  output logic [3:0]                  capture_out
);
  typedef struct packed {
    logic [3:0][7:0]  io;
    logic [15:0]      ctrl;
    logic [3:0]       cap_flag;
    logic [3:0][15:0] cap_val;
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } top_state_t;

  top_state_t  state_reg;
  top_state_t  state_next;
  logic [3:0]  pin_lvl;
  logic [3:0]  pin_rise;
  logic [3:0]  pin_fall;
  logic [3:0]  ch_level;
  logic [3:0]  ch_oe;
  logic [3:0]  ch_cap;
  logic [3:0]  ch_run;
  logic [3:0]  ch_cross;
  logic [3:0]  ch_ignore;
  logic [2:0]  psc1;
  logic [2:0]  psc4;

  assign psc1   = state_reg.ctrl[tiod_pkg::CTRL_PSC1_LSB +: tiod_pkg::PSC_W];
  assign psc4   = state_reg.ctrl[tiod_pkg::CTRL_PSC4_LSB +: tiod_pkg::PSC_W];
  assign ch_run = state_reg.ctrl[tiod_pkg::CTRL_RUN_LSB +: tiod_pkg::NUM_CH];

  assign ch_cross[0] = ch1_count_tick_in & (psc1 != tiod_pkg::PSC_UNDIVIDED);
  assign ch_cross[1] = ch0_c_event_in;
  assign ch_cross[2] = 1'b0;
  assign ch_cross[3] = ch4_count_tick_in & (psc4 != tiod_pkg::PSC_UNDIVIDED);
  assign ch_ignore = {3'h0, state_reg.ctrl[tiod_pkg::CTRL_DBUF_BIT]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      chan_if cbus ();
      pin_edge_sync u_sync (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .pin_in    (timer_pin_in[gi]),
        .level_out (pin_lvl[gi]),
        .rise_out  (pin_rise[gi]),
        .fall_out  (pin_fall[gi])
      );
      assign cbus.field       = state_reg.io[gi][tiod_pkg::FLD_LSB +: tiod_pkg::FLD_W];
      assign cbus.ignore      = ch_ignore[gi];
      assign cbus.run         = ch_run[gi];
      assign cbus.cross_event = ch_cross[gi];
      assign cbus.cmp_match   = cmp_match_in[gi];
      assign cbus.pin_rise    = pin_rise[gi];
      assign cbus.pin_fall    = pin_fall[gi];
      assign ch_level[gi]     = cbus.level;
      assign ch_oe[gi]        = cbus.oe;
      assign ch_cap[gi]       = cbus.capture;
      chan_decode #(
        .HAS_CROSS (tiod_pkg::CROSS_PRESENT[gi])
      ) u_chan (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .cbus    (cbus)
      );
    end
  endgenerate

  function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic strb);
    merge8 = strb ? new_v : old_v;
  endfunction : merge8

  always_comb begin
    logic       do_wr;
    logic       wr_hit;
    logic       rd_hit;
    logic [3:0] clr;
    logic [7:0] cap_off;
    do_wr      = 1'b0;
    wr_hit     = 1'b0;
    rd_hit     = 1'b0;
    clr        = 4'h0;
    cap_off    = 8'h00;
    state_next = state_reg;

    // write address and data taken in either order
    if (s_axi_awvalid_in && state_reg.awready) begin
      state_next.aw_got  = 1'b1;
      state_next.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata_in;
      state_next.wstrb = s_axi_wstrb_in;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      do_wr             = 1'b1;
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
    end
    if (state_reg.bvalid && s_axi_bready_in) begin
      state_next.bvalid = 1'b0;
    end

    if (do_wr) begin
      case (state_reg.aw_addr)
        tiod_pkg::OFF_CH0_IO: begin
          wr_hit           = 1'b1;
          state_next.io[0] = merge8(state_reg.io[0], state_reg.wdata[7:0], state_reg.wstrb[0]);
        end
        tiod_pkg::OFF_CH1_IO: begin
          wr_hit           = 1'b1;
          state_next.io[1] = merge8(state_reg.io[1], state_reg.wdata[7:0], state_reg.wstrb[0]);
        end
        tiod_pkg::OFF_CH2_IO: begin
          wr_hit           = 1'b1;
          state_next.io[2] = merge8(state_reg.io[2], state_reg.wdata[7:0], state_reg.wstrb[0]);
        end
        tiod_pkg::OFF_CH3_IO: begin
          wr_hit           = 1'b1;
          state_next.io[3] = merge8(state_reg.io[3], state_reg.wdata[7:0], state_reg.wstrb[0]);
        end
        tiod_pkg::OFF_CTRL: begin
          wr_hit                = 1'b1;
          state_next.ctrl[7:0]  = merge8(state_reg.ctrl[7:0], state_reg.wdata[7:0], state_reg.wstrb[0]);
          state_next.ctrl[15:8] = merge8(state_reg.ctrl[15:8], state_reg.wdata[15:8], state_reg.wstrb[1]);
        end
        tiod_pkg::OFF_STAT: begin
          wr_hit = 1'b1;
          if (state_reg.wstrb[1]) begin
            clr = state_reg.wdata[tiod_pkg::STAT_CAP_LSB +: tiod_pkg::NUM_CH];
          end
        end
        default: begin
          // capture value registers are read only
          for (int i = 0; i < 4; i++) begin
            cap_off = 8'(tiod_pkg::OFF_CAP0 + 8'(i) * tiod_pkg::OFF_STEP);
            if (state_reg.aw_addr == cap_off) begin
              wr_hit = 1'b1;
            end
          end
        end
      endcase
      state_next.bresp = wr_hit ? tiod_pkg::RESP_OKAY : tiod_pkg::RESP_SLVERR;
    end

    // capture latch; a new capture wins over a clear in the same cycle
    for (int i = 0; i < 4; i++) begin
      if (ch_cap[i]) begin
        state_next.cap_val[i] = count_in[i];
      end
    end
    state_next.cap_flag = (state_reg.cap_flag & ~clr) | ch_cap;

    // read channel
    if (state_reg.rvalid && s_axi_rready_in) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = 32'h0;
      case (s_axi_araddr_in)
        tiod_pkg::OFF_CH0_IO: begin
          rd_hit                 = 1'b1;
          state_next.rdata[7:0]  = state_reg.io[0];
        end
        tiod_pkg::OFF_CH1_IO: begin
          rd_hit                 = 1'b1;
          state_next.rdata[7:0]  = state_reg.io[1];
        end
        tiod_pkg::OFF_CH2_IO: begin
          rd_hit                 = 1'b1;
          state_next.rdata[7:0]  = state_reg.io[2];
        end
        tiod_pkg::OFF_CH3_IO: begin
          rd_hit                 = 1'b1;
          state_next.rdata[7:0]  = state_reg.io[3];
        end
        tiod_pkg::OFF_CTRL: begin
          rd_hit                 = 1'b1;
          state_next.rdata[15:0] = state_reg.ctrl;
        end
        tiod_pkg::OFF_STAT: begin
          rd_hit = 1'b1;
          state_next.rdata[tiod_pkg::STAT_LVL_LSB +: 4] = ch_level;
          state_next.rdata[tiod_pkg::STAT_OE_LSB +: 4]  = ch_oe;
          state_next.rdata[tiod_pkg::STAT_CAP_LSB +: 4] = state_reg.cap_flag;
          state_next.rdata[tiod_pkg::STAT_PIN_LSB +: 4] = pin_lvl;
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            cap_off = 8'(tiod_pkg::OFF_CAP0 + 8'(i) * tiod_pkg::OFF_STEP);
            if (s_axi_araddr_in == cap_off) begin
              rd_hit                 = 1'b1;
              state_next.rdata[15:0] = state_reg.cap_val[i];
            end
          end
        end
      endcase
      state_next.rresp = rd_hit ? tiod_pkg::RESP_OKAY : tiod_pkg::RESP_SLVERR;
    end

    state_next.awready = !state_next.aw_got && !state_next.bvalid;
    state_next.wready  = !state_next.w_got && !state_next.bvalid;
    state_next.arready = !state_next.rvalid;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg         <= '0;
      state_reg.io      <= {4{tiod_pkg::IO_RST}};
      state_reg.ctrl    <= tiod_pkg::CTRL_RST;
      state_reg.awready <= 1'b1;
      state_reg.wready  <= 1'b1;
      state_reg.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready_out = state_reg.awready;
  assign s_axi_wready_out  = state_reg.wready;
  assign s_axi_bresp_out   = state_reg.bresp;
  assign s_axi_bvalid_out  = state_reg.bvalid;
  assign s_axi_arready_out = state_reg.arready;
  assign s_axi_rdata_out   = state_reg.rdata;
  assign s_axi_rresp_out   = state_reg.rresp;
  assign s_axi_rvalid_out  = state_reg.rvalid;
  assign timer_pin_out     = ch_level;
  assign timer_pin_oe_out  = ch_oe;
  assign capture_out       = ch_cap;
endmodule : timer_io_control_decode

// ### tb/tiod_assertions.sv
// Purpose: port-level checks of the timer i/o control decode
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every timer_io_control_decode instance
`timescale 1ns/1ps
module tiod_checker (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [3:0]  timer_pin_in,
  input wire logic [3:0]  timer_pin_out,
  input wire logic [3:0]  cmp_match_in,
  input wire logic        ch1_count_tick_in,
  input wire logic        ch4_count_tick_in,
  input wire logic        ch0_c_event_in,
  input wire logic [3:0]  capture_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // a strobe needs an own-pin change in the sync window or a cross event
  AST_CAP0_CAUSE: assert property (capture_out[0] |->
    $past(timer_pin_in[0], 3) != $past(timer_pin_in[0], 5) || $past(ch1_count_tick_in))
    else $error("ch0 capture without cause");
  AST_CAP1_CAUSE: assert property (capture_out[1] |->
    $past(timer_pin_in[1], 3) != $past(timer_pin_in[1], 5) || $past(ch0_c_event_in))
    else $error("ch1 capture without cause");
  AST_CAP2_CAUSE: assert property (capture_out[2] |->
    $past(timer_pin_in[2], 3) != $past(timer_pin_in[2], 5))
    else $error("ch2 capture without pin edge");
  AST_CAP3_CAUSE: assert property (capture_out[3] |->
    $past(timer_pin_in[3], 3) != $past(timer_pin_in[3], 5) || $past(ch4_count_tick_in))
    else $error("ch3 capture without cause");
  // pin level moves only after a match or a register write
  AST_PIN_CAUSE: assert property (!$stable(timer_pin_out) |->
    $past(|cmp_match_in) || $past(s_axi_bvalid_out) || s_axi_bvalid_out)
    else $error("pin level changed without cause");
  AST_WR_RESP: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##2 s_axi_bvalid_out) else $error("write response late");
  AST_RD_RESP: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response late");
  AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  cover property (capture_out[0]);
  cover property (capture_out[3]);
  cover property ($rose(timer_pin_out[2]));
endmodule : tiod_checker
bind timer_io_control_decode tiod_checker tiod_checker_inst (.*);

// ### tb/pin_partner.sv
// Purpose: far side of the block: timer pins and neighbouring channels
// Assumes: event pulses last one clock
// Notes:   counter values are fixed per channel so captures are predictable
`timescale 1ns/1ps
module pin_partner (
  input  wire logic        clk_in,
  input  wire logic [3:0]  dut_level_in,
  input  wire logic [3:0]  dut_oe_in,
  output logic [3:0]       pin_wire_out,
  output logic [3:0]       cmp_match_out,
  output logic [3:0][15:0] count_out,
  output logic             ch1_tick_out,
  output logic             ch4_tick_out,
  output logic             c_event_out
);
  logic [3:0] pin_reg;
  logic [6:0] ev_reg;
  initial begin
    pin_reg = 4'h0;
    ev_reg = 7'h00;
  end
  // an undriven pin is held by the far side
  assign pin_wire_out = (dut_oe_in & dut_level_in) | (~dut_oe_in & pin_reg);
  assign cmp_match_out = ev_reg[3:0];
  assign ch1_tick_out = ev_reg[4];
  assign ch4_tick_out = ev_reg[5];
  assign c_event_out = ev_reg[6];
  always_comb begin
    for (int k = 0; k < 4; k++) count_out[k] = 16'ha000 + 16'(k);
  end
  task automatic set_pin(input int ch, input logic v);
    pin_reg[ch] <= v;
  endtask : set_pin
  task automatic pulse(input int idx);
    ev_reg[idx] <= 1'b1;
    @(posedge clk_in);
    ev_reg[idx] <= 1'b0;
  endtask : pulse
endmodule : pin_partner

// ### tb/testbench.sv
// Purpose: register-driven tests of the timer i/o control decode
// Assumes: 100 MHz clock, AXI4-Lite master tasks
// Notes:   capture strobes are counted per channel by a monitor
`timescale 1ns/1ps
module testbench;
  logic             clk_in, nrst_in, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, rd;
  logic [3:0]       wstrb, pin_wire, pin_lvl, pin_oe, cmp, capture;
  logic             awready, wready, bvalid, arready, rvalid, tick1, tick4, cevent;
  logic [1:0]       bresp, rresp, rr;
  logic [3:0][15:0] count;
  logic [3:0]       cross_exp [6] = '{4'h1, 4'h8, 4'h2, 4'h0, 4'h0, 4'h2};
  int               mismatches, checked;
  int               caps [4];
  timer_io_control_decode timer_io_control_decode_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .timer_pin_in(pin_wire), .timer_pin_out(pin_lvl), .timer_pin_oe_out(pin_oe), .cmp_match_in(cmp),
    .count_in(count), .ch1_count_tick_in(tick1), .ch4_count_tick_in(tick4), .ch0_c_event_in(cevent),
    .capture_out(capture));
  pin_partner pin_partner_inst (
    .clk_in(clk_in), .dut_level_in(pin_lvl), .dut_oe_in(pin_oe), .pin_wire_out(pin_wire),
    .cmp_match_out(cmp), .count_out(count), .ch1_tick_out(tick1), .ch4_tick_out(tick4), .c_event_out(cevent));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    for (int k = 0; k < 4; k++) if (capture[k] === 1'b1) caps[k]++;
  end
  task automatic end_of_test;
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1;
    do @(posedge clk_in); while (!bvalid);
    bready <= 1'b0;
    check(bresp, er);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    do @(posedge clk_in); while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axi_rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rd, rr);
    check(rd, e);
  endtask : rd_chk
  initial begin
    #300000;
    mismatches++;
    end_of_test();
  end
  initial begin
    {nrst_in, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    caps = '{4{0}};
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), 32'h0);
    axi_rd(8'hf0, rd, rr);
    check(rr, tiod_pkg::RESP_SLVERR);
    axi_wr(8'hf0, 32'h1, 4'hf, tiod_pkg::RESP_SLVERR);
    axi_wr(tiod_pkg::OFF_CH1_IO, 32'h5a, 4'he, tiod_pkg::RESP_OKAY);
    rd_chk(tiod_pkg::OFF_CH1_IO, 32'h0);
    axi_wr(tiod_pkg::OFF_CH1_IO, 32'h5a, 4'h1, tiod_pkg::RESP_OKAY);
    rd_chk(tiod_pkg::OFF_CH1_IO, 32'h5a);
    axi_wr(tiod_pkg::OFF_CH1_IO, 32'h0, 4'h1, tiod_pkg::RESP_OKAY);
    // initial level and enable for every compare code, counter stopped
    for (int code = 0; code < 8; code++) begin
      axi_wr(tiod_pkg::OFF_CH2_IO, 32'(code << 4), 4'h1, tiod_pkg::RESP_OKAY);
      idle(2);
      check(pin_lvl[2], code[2]);
      check(pin_oe[2], code[1:0] != 2'h0);
    end
    axi_wr(tiod_pkg::OFF_CH2_IO, 32'h50, 4'h1, tiod_pkg::RESP_OKAY);
    axi_wr(tiod_pkg::OFF_CTRL, 32'h4, 4'h3, tiod_pkg::RESP_OKAY);
    axi_wr(tiod_pkg::OFF_CH2_IO, 32'h10, 4'h1, tiod_pkg::RESP_OKAY);
    idle(2);
    check(pin_lvl[2], 1'b1);
    // clear, set, then toggle twice on matches
    for (int i = 0; i < 4; i++) begin
      axi_wr(tiod_pkg::OFF_CH2_IO, 32'((i < 2 ? i + 1 : 3) << 4), 4'h1, tiod_pkg::RESP_OKAY);
      pin_partner_inst.pulse(2);
      idle(2);
      check(pin_lvl[2], i[0]);
    end
    axi_wr(tiod_pkg::OFF_CH2_IO, 32'h0, 4'h1, tiod_pkg::RESP_OKAY);
    axi_wr(tiod_pkg::OFF_CTRL, 32'h110f, 4'h3, tiod_pkg::RESP_OKAY);
    // neighbour pin toggles first, then the own pin
    for (int ch = 0; ch < 4; ch++) begin
      for (int code = 8; code < 16; code++) begin
        if (code >= 12 && ch != 2) continue;
        axi_wr(8'(4 * ch), 32'(code << 4), 4'h1, tiod_pkg::RESP_OKAY);
        caps = '{4{0}};
        for (int p = 0; p < 4; p++) begin
          pin_partner_inst.set_pin(p < 2 ? (ch + 1) % 4 : ch, p[0] == 1'b0);
          idle(8);
        end
        check(caps[ch], code[1] ? 2 : 1);
        rd_chk(tiod_pkg::OFF_CAP0 + 8'(4 * ch), 32'ha000 + ch);
      end
      axi_wr(8'(4 * ch), 32'h0, 4'h1, tiod_pkg::RESP_OKAY);
    end
    for (int ch = 0; ch < 4; ch++) axi_wr(8'(4 * ch), 32'hc0, 4'h1, tiod_pkg::RESP_OKAY);
    // cross sources, then undivided prescale
    for (int i = 0; i < 6; i++) begin
      if (i == 3) axi_wr(tiod_pkg::OFF_CTRL, 32'h000f, 4'h3, tiod_pkg::RESP_OKAY);
      caps = '{4{0}};
      pin_partner_inst.pulse(4 + i % 3);
      idle(3);
      for (int ch = 0; ch < 4; ch++) check(caps[ch], cross_exp[i][ch]);
    end
    axi_wr(tiod_pkg::OFF_CTRL, 32'h0010, 4'h3, tiod_pkg::RESP_OKAY);
    axi_wr(tiod_pkg::OFF_CH0_IO, 32'h80, 4'h1, tiod_pkg::RESP_OKAY);
    caps = '{4{0}};
    pin_partner_inst.set_pin(0, 1'b1);
    idle(8);
    pin_partner_inst.set_pin(0, 1'b0);
    idle(8);
    check(caps[0], 0);
    // sticky capture flags from earlier captures, then write one to clear
    axi_rd(tiod_pkg::OFF_STAT, rd, rr);
    check(rd[tiod_pkg::STAT_CAP_LSB +: 4], 4'hf);
    axi_wr(tiod_pkg::OFF_STAT, 32'h0f00, 4'h2, tiod_pkg::RESP_OKAY);
    axi_rd(tiod_pkg::OFF_STAT, rd, rr);
    check(rd[tiod_pkg::STAT_CAP_LSB +: 4], 4'h0);
    end_of_test();
  end
endmodule : testbench
